// >>> inc/scgc_pkg.sv
package scgc_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_PS = 5000;
   localparam int STOP_TIME_NS  = 10000;
   localparam int STOP_CYCLES   = STOP_TIME_NS * 1000 / CLK_PERIOD_PS;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] SCC_OFF = 8'h00;
   localparam logic [7:0] CSC_OFF = 8'h04;
   localparam logic [7:0] PLL_OFF = 8'h08;
   localparam logic [7:0] FOC_OFF = 8'h0c;
   localparam logic [7:0] MOF_OFF = 8'h10;
   localparam logic [7:0] SOC_OFF = 8'h14;
   localparam logic [7:0] BCO_OFF = 8'h18;
   localparam logic [7:0] STS_OFF = 8'h1c;
   localparam logic [7:0] MSK_OFF = 8'h20;
   localparam logic [7:0] OSD_OFF = 8'h24;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int SCC_PERIPHERAL_CLOCK_A_DIVIDER_LSB = 0;
   localparam int SCC_PCKB_LSB = 4;
   localparam int SCC_PCKD_LSB = 8;
   localparam int SCC_PERIPHERAL_CLOCK_C_DIVIDER_LSB = 12;
   localparam int SCC_BCK_LSB  = 16;
   localparam int SCC_FCK_LSB  = 20;
   localparam int SCC_ICK_LSB  = 24;
   localparam int CSC_SEL_LSB  = 8;
   localparam int PLL_DIV_LSB  = 0;
   localparam int PLL_MUL_LSB  = 8;
   localparam int PLL_REF_BIT  = 16;
   localparam int FOC_FRQ_LSB  = 0;
   localparam int MOF_DRV_LSB  = 4;
   localparam int SOC_STP_BIT  = 0;
   localparam int BCO_EN_BIT   = 0;
   localparam int BCO_HALF_BIT = 1;
   localparam int STS_STOP_BIT = 0;
   localparam int STS_ELC_BIT  = 1;
   localparam int OSD_EN_BIT   = 0;
   localparam int OSD_HIZ_BIT  = 1;
   // ****************************************
   // Reset values and codes
   // ****************************************
   localparam logic [31:0] SCC_RST  = 32'h0000_1000;
   localparam logic [2:0]  CSC_RST  = 3'h0;
   localparam logic [1:0]  PDIV_RST = 2'h0;
   localparam logic [5:0]  PMUL_RST = 6'h13;
   localparam logic [5:0]  PMUL_MIN = 6'h13;
   localparam logic [5:0]  PMUL_MAX = 6'h3b;
   localparam logic [1:0]  FRQ_RST  = 2'h0;
   localparam logic [1:0]  DRV_RST  = 2'h0;
   localparam logic        SSTP_RST = 1'b1;
   localparam logic [3:0]  DIV_MAX  = 4'h6;
   localparam logic [1:0]  RESP_OK  = 2'h0;
   localparam logic [1:0]  RESP_ERR = 2'h2;
   typedef enum logic [2:0] {
      SCGC_SRC_SLOW = 3'b000,
      SCGC_SRC_FAST = 3'b001,
      SCGC_SRC_MAIN = 3'b010,
      SCGC_SRC_SUB  = 3'b011,
      SCGC_SRC_PLL  = 3'b100
   } scgc_src_t;
endpackage : scgc_pkg

// >>> verilog/scgc_top.sv
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module scgc_top (
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        slow_onchip_osc,
   input  wire logic        fast_onchip_osc,
   input  wire logic        main_osc,
   input  wire logic        subclock_osc,
   input  wire logic        pll_osc,
   input  wire logic        evt_switch_to_slow,
   output logic             evt_main_osc_stop,
   output logic             motor_timer_hiz,
   output logic             pll_ref_select,
   output logic [1:0]       pll_input_divider,
   output logic [6:0]       pll_factor_x2,
   output logic [1:0]       fast_osc_frequency_select,
   output logic [1:0]       main_osc_drive_range,
   output logic             subclock_osc_stop,
   output logic [2:0]       clock_source_active,
   output logic             system_clock,
   output logic             peripheral_clock_a,
   output logic             peripheral_clock_b,
   output logic             analog_conversion_clock,
   output logic             flash_interface_clock,
   output logic             bus_clock,
   output logic             bus_clock_pin,
   output logic             bus_clock_pin_oe,
   output logic             irq
);
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic [5:0] half_cnt(input logic [3:0] code);
      logic [3:0] c;
      c = (code > scgc_pkg::DIV_MAX) ? scgc_pkg::DIV_MAX : code;
      return 6'((7'h01 << c) - 7'h01);
   endfunction : half_cnt

   // ****************************************
   // Register file
   // ****************************************
   logic [31:0] scc_reg;
   logic [2:0]  csel_reg;
   logic [1:0]  pdiv_reg;
   logic [5:0]  pmul_reg;
   logic        pref_reg;
   logic [1:0]  frq_reg;
   logic [1:0]  drv_reg;
   logic        sstp_reg;
   logic [1:0]  bco_reg;
   logic [1:0]  sts_reg;
   logic [1:0]  msk_reg;
   logic [1:0]  osd_reg;
   logic        wr_go;
   logic [31:0] wv;
   logic [31:0] rd_next;
   logic        rd_hit;
   logic        wr_hit;
   logic        stop_evt;
   logic        force_slow;

   assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = ~s_axi_rvalid;
   assign force_slow    = stop_evt | evt_switch_to_slow;

   always_comb begin
      wv = 32'h0;
      wr_hit = 1'b1;
      unique case (s_axi_awaddr)
         scgc_pkg::SCC_OFF: wv = scc_reg;
         scgc_pkg::CSC_OFF: wv[scgc_pkg::CSC_SEL_LSB +: 3] = csel_reg;
         scgc_pkg::PLL_OFF: begin
            wv[scgc_pkg::PLL_DIV_LSB +: 2] = pdiv_reg;
            wv[scgc_pkg::PLL_MUL_LSB +: 6] = pmul_reg;
            wv[scgc_pkg::PLL_REF_BIT]      = pref_reg;
         end
         scgc_pkg::FOC_OFF: wv[scgc_pkg::FOC_FRQ_LSB +: 2] = frq_reg;
         scgc_pkg::MOF_OFF: wv[scgc_pkg::MOF_DRV_LSB +: 2] = drv_reg;
         scgc_pkg::SOC_OFF: wv[scgc_pkg::SOC_STP_BIT] = sstp_reg;
         scgc_pkg::BCO_OFF: wv[1:0] = bco_reg;
         scgc_pkg::STS_OFF: wv[1:0] = 2'h0;
         scgc_pkg::MSK_OFF: wv[1:0] = msk_reg;
         scgc_pkg::OSD_OFF: wv[1:0] = osd_reg;
         default:           wr_hit = 1'b0;
      endcase
      wv = merge(wv, s_axi_wdata, s_axi_wstrb);
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         scc_reg <= scgc_pkg::SCC_RST;
         pdiv_reg <= scgc_pkg::PDIV_RST;
         pmul_reg <= scgc_pkg::PMUL_RST;
         pref_reg <= 1'b0;
         frq_reg <= scgc_pkg::FRQ_RST;
         drv_reg <= scgc_pkg::DRV_RST;
         sstp_reg <= scgc_pkg::SSTP_RST;
         bco_reg <= 2'h0;
         msk_reg <= 2'h0;
         osd_reg <= 2'h0;
      end else if (wr_go) begin
         unique case (s_axi_awaddr)
            scgc_pkg::SCC_OFF: scc_reg <= wv;
            scgc_pkg::PLL_OFF: begin
               if (wv[scgc_pkg::PLL_DIV_LSB +: 2] != 2'h3) begin
                  pdiv_reg <= wv[scgc_pkg::PLL_DIV_LSB +: 2];
               end
               if (wv[scgc_pkg::PLL_MUL_LSB +: 6] >= scgc_pkg::PMUL_MIN &&
                   wv[scgc_pkg::PLL_MUL_LSB +: 6] <= scgc_pkg::PMUL_MAX) begin
                  pmul_reg <= wv[scgc_pkg::PLL_MUL_LSB +: 6];
               end
               pref_reg <= wv[scgc_pkg::PLL_REF_BIT];
            end
            scgc_pkg::FOC_OFF: begin
               if (wv[scgc_pkg::FOC_FRQ_LSB +: 2] != 2'h3) begin
                  frq_reg <= wv[scgc_pkg::FOC_FRQ_LSB +: 2];
               end
            end
            scgc_pkg::MOF_OFF: drv_reg <= wv[scgc_pkg::MOF_DRV_LSB +: 2];
            scgc_pkg::SOC_OFF: sstp_reg <= wv[scgc_pkg::SOC_STP_BIT];
            scgc_pkg::BCO_OFF: bco_reg <= wv[1:0];
            scgc_pkg::MSK_OFF: msk_reg <= wv[1:0];
            scgc_pkg::OSD_OFF: osd_reg <= wv[1:0];
            default: ;
         endcase
      end
   end

   // Hardware fallback wins over a software write
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         csel_reg <= scgc_pkg::CSC_RST;
      end else if (force_slow) begin
         csel_reg <= scgc_pkg::SCGC_SRC_SLOW;
      end else if (wr_go && s_axi_awaddr == scgc_pkg::CSC_OFF &&
                   wv[scgc_pkg::CSC_SEL_LSB +: 3] <= 3'h4) begin
         csel_reg <= wv[scgc_pkg::CSC_SEL_LSB +: 3];
      end
   end

   // Sticky status, set wins over write-one-to-clear
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sts_reg <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (i == scgc_pkg::STS_STOP_BIT && stop_evt) begin
               sts_reg[i] <= 1'b1;
            end else if (i == scgc_pkg::STS_ELC_BIT && evt_switch_to_slow) begin
               sts_reg[i] <= 1'b1;
            end else if (wr_go && s_axi_awaddr == scgc_pkg::STS_OFF &&
                         wv[i]) begin
               sts_reg[i] <= 1'b0;
            end
         end
      end
   end

   assign irq = |(sts_reg & msk_reg);

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= scgc_pkg::RESP_OK;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? scgc_pkg::RESP_OK : scgc_pkg::RESP_ERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_comb begin
      rd_next = 32'h0;
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         scgc_pkg::SCC_OFF: rd_next = scc_reg;
         scgc_pkg::CSC_OFF: rd_next[scgc_pkg::CSC_SEL_LSB +: 3] = csel_reg;
         scgc_pkg::PLL_OFF: begin
            rd_next[scgc_pkg::PLL_DIV_LSB +: 2] = pdiv_reg;
            rd_next[scgc_pkg::PLL_MUL_LSB +: 6] = pmul_reg;
            rd_next[scgc_pkg::PLL_REF_BIT]      = pref_reg;
         end
         scgc_pkg::FOC_OFF: rd_next[scgc_pkg::FOC_FRQ_LSB +: 2] = frq_reg;
         scgc_pkg::MOF_OFF: rd_next[scgc_pkg::MOF_DRV_LSB +: 2] = drv_reg;
         scgc_pkg::SOC_OFF: rd_next[scgc_pkg::SOC_STP_BIT] = sstp_reg;
         scgc_pkg::BCO_OFF: rd_next[1:0] = bco_reg;
         scgc_pkg::STS_OFF: rd_next[1:0] = sts_reg;
         scgc_pkg::MSK_OFF: rd_next[1:0] = msk_reg;
         scgc_pkg::OSD_OFF: rd_next[1:0] = osd_reg;
         default:           rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= scgc_pkg::RESP_OK;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_next;
         s_axi_rresp  <= rd_hit ? scgc_pkg::RESP_OK : scgc_pkg::RESP_ERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************
   // Main oscillator stop detection
   // ****************************************
   logic [4:0]  osc_q;
   logic [4:0]  osc_prev;
   logic [11:0] quiet_cnt;
   logic        stop_seen;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         osc_q    <= 5'h0;
         osc_prev <= 5'h0;
      end else begin
         osc_q    <= {pll_osc, subclock_osc, main_osc, fast_onchip_osc,
                      slow_onchip_osc};
         osc_prev <= osc_q;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         quiet_cnt <= 12'h0;
         stop_seen <= 1'b0;
      end else if (osc_q[2] != osc_prev[2]) begin
         quiet_cnt <= 12'h0;
         stop_seen <= 1'b0;
      end else if (quiet_cnt != 12'(scgc_pkg::STOP_CYCLES)) begin
         quiet_cnt <= quiet_cnt + 12'h1;
      end else if (osd_reg[scgc_pkg::OSD_EN_BIT]) begin
         stop_seen <= 1'b1;
      end
   end

   assign stop_evt = osd_reg[scgc_pkg::OSD_EN_BIT] & ~stop_seen &
                     (quiet_cnt == 12'(scgc_pkg::STOP_CYCLES)) &
                     (osc_q[2] == osc_prev[2]);

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         evt_main_osc_stop <= 1'b0;
         motor_timer_hiz   <= 1'b0;
      end else begin
         evt_main_osc_stop <= stop_evt;
         motor_timer_hiz   <= stop_seen & osd_reg[scgc_pkg::OSD_HIZ_BIT];
      end
   end

   // ****************************************
   // Source switch and dividers
   // ****************************************
   logic [2:0] src_act_reg;
   logic [5:0] clk_q;
   logic       tick;
   logic [3:0] code [6];

   assign code[0] = scc_reg[scgc_pkg::SCC_ICK_LSB +: 4];
   assign code[1] = scc_reg[scgc_pkg::SCC_PERIPHERAL_CLOCK_A_DIVIDER_LSB +: 4];
   assign code[2] = scc_reg[scgc_pkg::SCC_PCKB_LSB +: 4];
   assign code[3] = scc_reg[scgc_pkg::SCC_PCKD_LSB +: 4];
   assign code[4] = scc_reg[scgc_pkg::SCC_FCK_LSB +: 4];
   assign code[5] = scc_reg[scgc_pkg::SCC_BCK_LSB +: 4];
   assign tick = osc_q[src_act_reg] & ~osc_prev[src_act_reg];

   // New source taken only while every clock rests low
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         src_act_reg <= scgc_pkg::CSC_RST;
      end else if (clk_q == 6'h0) begin
         src_act_reg <= csel_reg;
      end
   end

   generate
      for (genvar g = 0; g < 6; g++) begin : g_div
         logic [5:0] cnt_reg;
         logic [3:0] act_reg;
         always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
               cnt_reg  <= 6'h0;
               act_reg  <= 4'h0;
               clk_q[g] <= 1'b0;
            end else if (tick) begin
               if (cnt_reg != 6'h0) begin
                  cnt_reg <= cnt_reg - 6'h1;
               end else if (clk_q[g]) begin
                  clk_q[g] <= 1'b0;
                  act_reg  <= code[g];
                  cnt_reg  <= half_cnt(code[g]);
               end else begin
                  clk_q[g] <= 1'b1;
                  cnt_reg  <= half_cnt(act_reg);
               end
            end
         end
      end
   endgenerate

   // ****************************************
   // Outputs
   // ****************************************
   logic bus_half_reg;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         bus_half_reg <= 1'b0;
      end else if (tick && clk_q[5] && g_div[5].cnt_reg == 6'h0) begin
         bus_half_reg <= ~bus_half_reg;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         bus_clock_pin <= 1'b1;
      end else if (!bco_reg[scgc_pkg::BCO_EN_BIT]) begin
         bus_clock_pin <= 1'b1;
      end else begin
         bus_clock_pin <= bco_reg[scgc_pkg::BCO_HALF_BIT] ?
                          bus_half_reg : clk_q[5];
      end
   end

   assign bus_clock_pin_oe          = 1'b1;
   assign system_clock              = clk_q[0];
   assign peripheral_clock_a        = clk_q[1];
   assign peripheral_clock_b        = clk_q[2];
   assign analog_conversion_clock   = clk_q[3];
   assign flash_interface_clock     = clk_q[4];
   assign bus_clock                 = clk_q[5];
   assign clock_source_active       = src_act_reg;
   assign pll_ref_select            = pref_reg;
   assign pll_input_divider         = pdiv_reg;
   assign pll_factor_x2             = 7'(pmul_reg) + 7'h01;
   assign fast_osc_frequency_select = frq_reg;
   assign main_osc_drive_range      = drv_reg;
   assign subclock_osc_stop         = sstp_reg;
endmodule : scgc_top

// >>> tb/scgc_properties.sv
`timescale 1ns/10ps
module scgc_properties (
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   input wire logic       evt_switch_to_slow,
   input wire logic       evt_main_osc_stop,
   input wire logic       motor_timer_hiz,
   input wire logic [1:0] pll_input_divider,
   input wire logic [6:0] pll_factor_x2,
   input wire logic [1:0] fast_osc_frequency_select,
   input wire logic [2:0] clock_source_active,
   input wire logic       system_clock,
   input wire logic       peripheral_clock_a,
   input wire logic       bus_clock,
   input wire logic       bus_clock_pin_oe
);
   // ****************************************
   // Clocking
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // ****************************************
   // Properties
   // ****************************************
   property p_src_code; clock_source_active <= 3'h4; endproperty
   a_src_code: assert property (p_src_code)
      else $error("unknown clock source in use");
   property p_div_legal; pll_input_divider != 2'h3; endproperty
   a_div_legal: assert property (p_div_legal)
      else $error("bad pll divider");
   property p_factor;
      pll_factor_x2 >= 7'h14 && pll_factor_x2 <= 7'h3c;
   endproperty
   a_factor: assert property (p_factor)
      else $error("pll factor out of range");
   property p_frq; fast_osc_frequency_select != 2'h3; endproperty
   a_frq: assert property (p_frq)
      else $error("bad fast osc code");
   property p_evt_slow;
      evt_switch_to_slow |-> ##[1:600] clock_source_active == 3'h0;
   endproperty
   a_evt_slow: assert property (p_evt_slow)
      else $error("event did not select slow oscillator");
   property p_stop_pulse; evt_main_osc_stop |=> !evt_main_osc_stop; endproperty
   a_stop_pulse: assert property (p_stop_pulse)
      else $error("stop event longer than one cycle");
   property p_hiz;
      $rose(motor_timer_hiz) |-> evt_main_osc_stop || $past(evt_main_osc_stop);
   endproperty
   a_hiz: assert property (p_hiz)
      else $error("timer float without oscillator stop");
   property p_oe; bus_clock_pin_oe; endproperty
   a_oe: assert property (p_oe)
      else $error("bus clock pin not driven");
   property p_sys_min; $changed(system_clock) |=> $stable(system_clock); endproperty
   a_sys_min: assert property (p_sys_min)
      else $error("runt pulse on system clock");
   property p_pca_min;
      $rose(peripheral_clock_a) |=> peripheral_clock_a[*1];
   endproperty
   a_pca_min: assert property (p_pca_min)
      else $error("runt pulse on peripheral clock a");
   property p_switch_low;
      $changed(clock_source_active) |-> !$past(system_clock)
         && !$past(peripheral_clock_a) && !$past(bus_clock);
   endproperty
   a_switch_low: assert property (p_switch_low)
      else $error("switch while a clock high");
   c_evt: cover property (evt_switch_to_slow);
   c_stop: cover property (evt_main_osc_stop);
   c_switch: cover property ($changed(clock_source_active));
endmodule : scgc_properties

// >>> tb/system_clock_generation_control_tb.sv
`timescale 1ns/10ps
module system_clock_generation_control_tb;
   logic        clk_sys = 1'b0, sys_rst = 1'b1, main_run = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, osc_cnt = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, mdl [10];
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, evt_switch_to_slow = 1'b0;
   logic        slow_onchip_osc = 1'b0, fast_onchip_osc = 1'b0, main_osc = 1'b0;
   logic        subclock_osc = 1'b0, pll_osc = 1'b0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, evt_main_osc_stop;
   logic        motor_timer_hiz, pll_ref_select, subclock_osc_stop, system_clock;
   logic        peripheral_clock_a, peripheral_clock_b, analog_conversion_clock;
   logic        flash_interface_clock, bus_clock, bus_clock_pin, bus_clock_pin_oe;
   logic        irq;
   logic [1:0]  s_axi_bresp, s_axi_rresp, pll_input_divider;
   logic [1:0]  fast_osc_frequency_select, main_osc_drive_range;
   logic [6:0]  pll_factor_x2;
   logic [2:0]  clock_source_active;
   int          mismatches = 0, n_checks = 0;
   always #2.5 clk_sys = ~clk_sys;
   // ****************************************
   // Oscillator stand-ins
   // ****************************************
   always @(posedge clk_sys) begin
      osc_cnt <= osc_cnt + 8'h01;
      slow_onchip_osc <= osc_cnt[3];
      fast_onchip_osc <= osc_cnt[1];
      if (main_run) main_osc <= osc_cnt[2];
      subclock_osc <= osc_cnt[4];
      pll_osc <= osc_cnt[1];
   end
   scgc_top dut (.*);
   // ****************************************
   // Checking and bus tasks
   // ****************************************
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   function automatic void mwr(input int i, input logic [31:0] d);
      case (i)
         1: if (d[10:8] <= 3'h4) mdl[1] = d & 32'h700;
         2: begin
            if (d[1:0] != 2'h3) mdl[2][1:0] = d[1:0];
            if (d[13:8] >= 6'h13 && d[13:8] <= 6'h3b) mdl[2][13:8] = d[13:8];
            mdl[2][16] = d[16];
         end
         3: if (d[1:0] != 2'h3) mdl[3] = d & 32'h3;
         7: mdl[7] = mdl[7] & ~d;
         default: mdl[i] = d & (i == 0 ? 32'h0fff_ffff : i == 4 ? 32'h30 :
                                i == 5 ? 32'h1 : 32'h3);
      endcase
   endfunction : mwr
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, da, dw, b;
      logic [1:0] r;
      da = 1'b0;
      dw = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(da && dw)) begin
         #4;
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         @(posedge clk_sys);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         da = da | ta;
         dw = dw | tw;
      end
      s_axi_bready <= 1'b1;
      do begin
         #4;
         b = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clk_sys);
      end while (!b);
      s_axi_bready <= 1'b0;
      chk(r, a < 8'h28 ? scgc_pkg::RESP_OK : scgc_pkg::RESP_ERR);
      if (a < 8'h28) mwr(a[7:2], d);
   endtask : axw
   task automatic axr(input logic [7:0] a);
      logic v;
      logic [31:0] d;
      logic [1:0] r;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         #4;
         v = s_axi_arready;
         @(posedge clk_sys);
      end while (!v);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do begin
         #4;
         v = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clk_sys);
      end while (!v);
      s_axi_rready <= 1'b0;
      chk(d, a < 8'h28 ? mdl[a[7:2]] : 32'h0);
      chk(r, a < 8'h28 ? scgc_pkg::RESP_OK : scgc_pkg::RESP_ERR);
   endtask : axr
   task automatic wait_src(input logic [2:0] e);
      repeat (2000) begin
         #4;
         if (clock_source_active === e) break;
         @(posedge clk_sys);
      end
      chk(clock_source_active, e);
      @(posedge clk_sys);
   endtask : wait_src
   function automatic logic pick(input int w);
      return w == 0 ? peripheral_clock_a : w == 1 ? bus_clock :
             w == 2 ? bus_clock_pin : analog_conversion_clock;
   endfunction : pick
   task automatic hi_len(input int w, output int n);
      logic v;
      int k;
      for (int st = 0; st < 4; st++) begin
         k = 0;
         do begin
            #4;
            v = pick(w);
            @(posedge clk_sys);
            k++;
         end while (v !== (st % 2 == 0) && k < 6000);
      end
      n = k;
   endtask : hi_len
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      logic [2:0] src_tbl [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
      logic [5:0] mul_tbl [5];
      logic [5:0] mul;
      int n, c, lo;
      for (int i = 0; i < 10; i++) mdl[i] = 32'h0;
      mdl[0] = scgc_pkg::SCC_RST;
      mdl[2] = 32'h0000_1300;
      mdl[5] = 32'h1;
      void'($urandom(49947));
      mul_tbl = '{6'h13, 6'h3b, 6'h12, 6'h3c, 6'h13 + 6'($urandom % 41)};
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      for (int i = 0; i < 11; i++) axr(8'(i * 4));
      chk(pll_factor_x2, 32'd20);
      chk(subclock_osc_stop, 32'h1);
      for (int i = 0; i < 6; i++) begin
         axw(scgc_pkg::CSC_OFF, {21'h0, src_tbl[i], 8'h00});
         wait_src(mdl[1][10:8]);
         axr(scgc_pkg::CSC_OFF);
      end
      for (int i = 0; i < 5; i++) begin
         mul = mul_tbl[i];
         axw(scgc_pkg::PLL_OFF, {15'h0, i[0], 2'h0, mul, 6'h0, i[1:0]});
         chk(pll_input_divider, mdl[2][1:0]);
         chk(pll_factor_x2, mdl[2][13:8] + 1);
         chk(pll_ref_select, mdl[2][16]);
         axr(scgc_pkg::PLL_OFF);
      end
      for (int k = 0; k < 4; k++) begin
         axw(scgc_pkg::FOC_OFF, 32'(k));
         axw(scgc_pkg::MOF_OFF, 32'(k) << 4);
         axw(scgc_pkg::SOC_OFF, 32'(k % 2));
         chk(fast_osc_frequency_select, mdl[3][1:0]);
         chk(main_osc_drive_range, mdl[4][5:4]);
         chk(subclock_osc_stop, mdl[5][0]);
         axr(scgc_pkg::FOC_OFF);
      end
      c = $urandom % 3;
      axw(scgc_pkg::SCC_OFF, 32'h1000 | 32'(c) | (32'($urandom % 3) << 4));
      axr(scgc_pkg::SCC_OFF);
      hi_len(0, n);
      chk(n, 16 << c);
      axw(scgc_pkg::SCC_OFF, 32'h1000);
      hi_len(1, n);
      chk(n, 16);
      hi_len(3, n);
      chk(n, 16);
      axw(scgc_pkg::BCO_OFF, 32'h0);
      lo = 0;
      repeat (40) begin
         #4;
         lo += (bus_clock_pin !== 1'b1);
         @(posedge clk_sys);
      end
      chk(lo, 0);
      axw(scgc_pkg::BCO_OFF, 32'h1);
      hi_len(2, n);
      chk(n, 16);
      axw(scgc_pkg::BCO_OFF, 32'h3);
      hi_len(2, n);
      chk(n, 32);
      for (int k = 0; k < 2; k++) begin
         axw(scgc_pkg::MSK_OFF, k == 0 ? 32'h2 : 32'h0);
         axw(scgc_pkg::CSC_OFF, 32'h100);
         wait_src(3'h1);
         evt_switch_to_slow <= 1'b1;
         @(posedge clk_sys);
         evt_switch_to_slow <= 1'b0;
         mdl[7][1] = 1'b1;
         mdl[1] = 32'h0;
         wait_src(3'h0);
         axr(scgc_pkg::STS_OFF);
         axr(scgc_pkg::CSC_OFF);
         #4;
         chk(irq, 32'(k == 0));
         @(posedge clk_sys);
         axw(scgc_pkg::STS_OFF, 32'h2);
         #4;
         chk(irq, 32'h0);
         @(posedge clk_sys);
      end
      axw(scgc_pkg::OSD_OFF, 32'h3);
      axw(scgc_pkg::MSK_OFF, 32'h1);
      axw(scgc_pkg::CSC_OFF, 32'h100);
      wait_src(3'h1);
      main_run <= 1'b0;
      n = 0;
      do begin
         #4;
         lo = evt_main_osc_stop;
         @(posedge clk_sys);
         n++;
      end while (lo != 1 && n < 3000);
      main_run <= 1'b1;
      chk(32'(n >= scgc_pkg::STOP_CYCLES - 8 &&
              n <= scgc_pkg::STOP_CYCLES + 8), 32'h1);
      mdl[7][0] = 1'b1;
      mdl[1] = 32'h0;
      #4;
      chk(motor_timer_hiz, 32'h1);
      chk(irq, 32'h1);
      @(posedge clk_sys);
      wait_src(3'h0);
      axr(scgc_pkg::STS_OFF);
      axr(scgc_pkg::CSC_OFF);
      axw(scgc_pkg::OSD_OFF, 32'h0);
      axw(scgc_pkg::STS_OFF, 32'h1);
      axw(8'h40, 32'hffff_ffff);
      for (int i = 0; i < 11; i++) axr(8'(i * 4));
      axr(8'h40);
      complete_run();
   end
   initial begin
      repeat (60000) @(posedge clk_sys);
      mismatches++;
      complete_run();
   end
endmodule : system_clock_generation_control_tb
bind scgc_top scgc_properties u_props (.*);
